// ---- logic/dhi_pkg.sv ----
// Shared constants, pin map and state encodings for the display host interface.
package dhi_pkg;

	localparam int          DHI_BUS_W     = 18;
	localparam int          DHI_COLS      = 240;
	localparam int          DHI_ROWS      = 240;
	localparam logic [7:0]  DHI_COLS_LIM  = 8'hf0;
	localparam logic [7:0]  DHI_ROWS_LIM  = 8'hf0;
	localparam logic [3:0]  DHI_SER_LEN4  = 4'h8;
	localparam logic [3:0]  DHI_SER_LEN3  = 4'h9;
	localparam logic [3:0]  DHI_SER_STEP1 = 4'h1;
	localparam logic [3:0]  DHI_SER_STEP2 = 4'h2;
	localparam int          DHI_RD_BITS   = 8;

	// Positions inside the synchronised vector of single-bit pins.
	localparam int          DHI_PIN_W     = 15;
	localparam int          DHI_P_VS      = 0;
	localparam int          DHI_P_HS      = 1;
	localparam int          DHI_P_DE      = 2;
	localparam int          DHI_P_PCLK    = 3;
	localparam int          DHI_P_SDI     = 4;
	localparam int          DHI_P_RDB     = 5;
	localparam int          DHI_P_WRB     = 6;
	localparam int          DHI_P_DCX     = 7;
	localparam int          DHI_P_CSB     = 8;
	localparam int          DHI_P_FMT     = 9;
	localparam int          DHI_P_TWO     = 10;
	localparam int          DHI_P_FOUR    = 11;
	localparam int          DHI_P_IM      = 12;
	localparam int          DHI_P_MODE    = 13;
	// Idle-high pins (syncs, strobes, chip select, serial clock) reset high so no false edge appears.
	localparam logic [14:0] DHI_PIN_RST   = 15'h01e3;
	localparam logic [17:0] DHI_BUS_RST   = 18'h00000;

	typedef enum logic [1:0] {
		DHI_MODE_SERIAL = 2'b00,
		DHI_MODE_MCU    = 2'b01,
		DHI_MODE_RGB    = 2'b10
	} dhi_mode_e;

	typedef enum logic [1:0] {
		DHI_SER_IDLE  = 2'b00,
		DHI_SER_SHIFT = 2'b01,
		DHI_SER_READ  = 2'b11
	} dhi_ser_e;

endpackage : dhi_pkg

// ---- logic/dhi_sync.sv ----
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module dhi_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : dhi_sync
`default_nettype wire

// ---- logic/dhi_top.sv ----
// Host-facing pin interface of a 240x240 colour display: serial, MCU and RGB paths.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Serial data sampled on serial clock rise
// - Select low: data line bidirectional, else input
// - Select one means data, zero means command
// - Read strobe drives bus; host captures at rise
// - Shared 18-bit bus for MCU and RGB
// - Four-wire serial: write strobe carries data/command
// - Two-line serial: write strobe is second data
// - Data/command pin is serial clock in serial
// - Accept 262k colours, 65k format expanded (code expands RGB pixels only; MCU words pass raw)
// - Frame is 240 by 240 pixels
module dhi_top
	import dhi_pkg::*;
#(
	parameter int RD_BITS = DHI_RD_BITS
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [1:0]  mode_sel,
	input  wire logic        interface_select_pin,
	input  wire logic        four_wire_sel,
	input  wire logic        two_line_sel,
	input  wire logic        pixel_format_65k,
	input  wire logic        chip_select_b,
	input  wire logic        data_command_select,
	input  wire logic        write_strobe_b,
	input  wire logic        read_strobe_b,
	input  wire logic [17:0] parallel_data_bus_in,
	output logic      [17:0] parallel_data_bus_out,
	output logic             parallel_data_bus_oe,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	input  wire logic        dot_clock,
	input  wire logic        pixel_data_enable,
	input  wire logic        line_sync_b,
	input  wire logic        frame_sync_b,
	input  wire logic [17:0] read_word,
	input  wire logic        read_go,
	output logic             word_valid,
	output logic      [17:0] word_data,
	output logic             word_is_data,
	output logic             pixel_valid,
	output logic      [17:0] pixel_data,
	output logic      [7:0]  pixel_x,
	output logic      [7:0]  pixel_y,
	output logic             frame_start
);

	//////////////////////////////////////////////////////////////////////////////////////////
	logic                 rst_n;
	logic [DHI_PIN_W-1:0] pins_raw;
	logic [DHI_PIN_W-1:0] pins_s;
	logic [17:0]          bus_s;

	// Reset asserts at once but is released on the clock, so no flop sees a half-released reset.
	dhi_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (.clk(clk), .rst_b(rst_b), .d(1'b1), .q(rst_n));

	assign pins_raw = {mode_sel, interface_select_pin, four_wire_sel, two_line_sel, pixel_format_65k,
		chip_select_b, data_command_select, write_strobe_b, read_strobe_b, serial_data_in,
		dot_clock, pixel_data_enable, line_sync_b, frame_sync_b};

	dhi_sync #(.W(DHI_PIN_W), .RST_VAL(DHI_PIN_RST)) u_pin_sync (.clk(clk), .rst_b(rst_n), .d(pins_raw), .q(pins_s));
	dhi_sync #(.W(DHI_BUS_W), .RST_VAL(DHI_BUS_RST)) u_bus_sync (.clk(clk), .rst_b(rst_n),
		.d(parallel_data_bus_in), .q(bus_s));

	//////////////////////////////////////////////////////////////////////////////////////////
	dhi_mode_e mode_s;
	logic      im_s, four_s, two_s, fmt_s, cs_s, dcx_s, wrb_s, rdb_s, sdi_s, pclk_s, de_s, hs_s, vs_s;
	logic      [DHI_PIN_W-1:0] prev_q;
	logic      ser_active, mcu_active, rgb_active;
	logic      scl_rise, scl_fall, wr_rise, rd_fall, pclk_rise, hs_fall, vs_fall;

	assign mode_s     = dhi_mode_e'(pins_s[DHI_P_MODE +: 2]);
	assign im_s       = pins_s[DHI_P_IM];
	assign four_s     = pins_s[DHI_P_FOUR];
	assign two_s      = pins_s[DHI_P_TWO];
	assign fmt_s      = pins_s[DHI_P_FMT];
	assign cs_s       = ~pins_s[DHI_P_CSB];
	assign dcx_s      = pins_s[DHI_P_DCX];
	assign wrb_s      = pins_s[DHI_P_WRB];
	assign rdb_s      = pins_s[DHI_P_RDB];
	assign sdi_s      = pins_s[DHI_P_SDI];
	assign pclk_s     = pins_s[DHI_P_PCLK];
	assign de_s       = pins_s[DHI_P_DE];
	assign hs_s       = pins_s[DHI_P_HS];
	assign vs_s       = pins_s[DHI_P_VS];

	// Serial commands also run alongside the RGB stream, so only MCU mode disables them.
	assign ser_active = (mode_s != DHI_MODE_MCU);
	assign mcu_active = (mode_s == DHI_MODE_MCU);
	assign rgb_active = (mode_s == DHI_MODE_RGB);
	assign scl_rise   = dcx_s & ~prev_q[DHI_P_DCX];
	assign scl_fall   = ~dcx_s & prev_q[DHI_P_DCX];
	assign wr_rise    = wrb_s & ~prev_q[DHI_P_WRB];
	assign rd_fall    = ~rdb_s & prev_q[DHI_P_RDB];
	assign pclk_rise  = pclk_s & ~prev_q[DHI_P_PCLK];
	assign hs_fall    = ~hs_s & prev_q[DHI_P_HS];
	assign vs_fall    = ~vs_s & prev_q[DHI_P_VS];

	// The previous copy resets to the synchroniser's own reset value, so no edge is seen after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= DHI_PIN_RST;
		end else begin
			prev_q <= pins_s;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	dhi_ser_e    ser_state_q, ser_state_d;
	logic [3:0]  ser_cnt_q, ser_cnt_d, ser_len;
	logic [8:0]  ser_sh_q, ser_sh_d;
	logic [17:0] rd_sh_q, rd_sh_d;
	logic [4:0]  rd_cnt_q, rd_cnt_d;
	logic        sda_out_d, sda_oe_d;
	logic        ser_word_v, ser_dc, ser_shift_ok;
	logic [7:0]  ser_byte;

	// Two-line framing wins over four-wire, since both claim the write strobe pin.
	assign ser_len      = (four_s && !two_s) ? DHI_SER_LEN4 : DHI_SER_LEN3;
	assign ser_shift_ok = (ser_state_q == DHI_SER_SHIFT) && ser_active && cs_s && !(read_go && !im_s);

	always_comb begin
		ser_state_d = ser_state_q;
		ser_cnt_d   = ser_cnt_q;
		ser_sh_d    = ser_sh_q;
		rd_sh_d     = rd_sh_q;
		rd_cnt_d    = rd_cnt_q;
		sda_out_d   = serial_data_out;
		sda_oe_d    = serial_data_oe & ~im_s;
		ser_word_v  = 1'b0;
		ser_dc      = 1'b0;
		ser_byte    = 8'h00;
		if (!ser_active || !cs_s) begin
			ser_state_d = DHI_SER_IDLE;
			ser_cnt_d   = 4'h0;
			sda_oe_d    = 1'b0;
		end else begin
			case (ser_state_q)
				DHI_SER_IDLE: begin
					ser_state_d = DHI_SER_SHIFT;
					ser_cnt_d   = 4'h0;
				end
				DHI_SER_SHIFT: begin
					if (read_go && !im_s) begin
						ser_state_d = DHI_SER_READ;
						rd_sh_d     = read_word;
						rd_cnt_d    = 5'h00;
					end else if (scl_rise) begin
						if (two_s && ser_cnt_q != 4'h0) begin
							ser_sh_d  = {ser_sh_q[6:0], sdi_s, wrb_s};
							ser_cnt_d = ser_cnt_q + DHI_SER_STEP2;
						end else begin
							ser_sh_d  = {ser_sh_q[7:0], sdi_s};
							ser_cnt_d = ser_cnt_q + DHI_SER_STEP1;
						end
						if (ser_cnt_d == ser_len) begin
							ser_word_v = 1'b1;
							ser_byte   = ser_sh_d[7:0];
							ser_dc     = (ser_len == DHI_SER_LEN4) ? wrb_s : ser_sh_d[8];
							ser_cnt_d  = 4'h0;
						end
					end
				end
				DHI_SER_READ: begin
					if (scl_fall) begin
						if (rd_cnt_q == 5'(RD_BITS)) begin
							ser_state_d = DHI_SER_SHIFT;
							sda_oe_d    = 1'b0;
						end else begin
							sda_out_d = rd_sh_q[RD_BITS-1];
							sda_oe_d  = ~im_s;
							rd_sh_d   = {rd_sh_q[16:0], 1'b0};
							rd_cnt_d  = rd_cnt_q + 5'h01;
						end
					end
				end
				default: begin
					ser_state_d = DHI_SER_IDLE;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	logic        word_valid_d, word_is_data_d, bus_oe_d, mcu_word_v;
	logic [17:0] word_data_d, bus_out_d;

	assign mcu_word_v = mcu_active && cs_s && wr_rise;

	always_comb begin
		word_valid_d   = ser_word_v | mcu_word_v;
		word_data_d    = word_data;
		word_is_data_d = word_is_data;
		if (ser_word_v) begin
			word_data_d    = {10'h000, ser_byte};
			word_is_data_d = ser_dc;
		end else if (mcu_word_v) begin
			word_data_d    = bus_s;
			word_is_data_d = dcx_s;
		end
		// The bus stays released until the strobe is seen low, and the host must not drive it then.
		bus_oe_d  = mcu_active && cs_s && !rdb_s;
		bus_out_d = rd_fall ? read_word : parallel_data_bus_out;
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  x_q, x_d, y_q, y_d, pix_x_d, pix_y_d;
	logic        line_seen_q, line_seen_d, pix_valid_d, frame_start_d;
	logic [17:0] pix_data_d;

	always_comb begin
		x_d           = x_q;
		y_d           = y_q;
		line_seen_d   = line_seen_q;
		pix_valid_d   = 1'b0;
		pix_data_d    = pixel_data;
		pix_x_d       = pixel_x;
		pix_y_d       = pixel_y;
		frame_start_d = 1'b0;
		if (rgb_active) begin
			if (vs_fall) begin
				x_d           = 8'h00;
				y_d           = 8'h00;
				line_seen_d   = 1'b0;
				frame_start_d = 1'b1;
			end else if (hs_fall) begin
				x_d         = 8'h00;
				line_seen_d = 1'b0;
				if (line_seen_q && y_q != DHI_ROWS_LIM) begin
					y_d = y_q + 8'h01;
				end
			end else if (pclk_rise && de_s) begin
				// Pixels past the 240x240 array are dropped rather than wrapped onto visible ones.
				if (x_q != DHI_COLS_LIM && y_q != DHI_ROWS_LIM) begin
					pix_valid_d = 1'b1;
					pix_x_d     = x_q;
					pix_y_d     = y_q;
					x_d         = x_q + 8'h01;
					line_seen_d = 1'b1;
					if (fmt_s) begin
						pix_data_d = {bus_s[15:11], bus_s[15], bus_s[10:5], bus_s[4:0], bus_s[4]};
					end else begin
						pix_data_d = bus_s;
					end
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state_q           <= DHI_SER_IDLE;
			ser_cnt_q             <= 4'h0;
			ser_sh_q              <= 9'h000;
			rd_sh_q               <= 18'h00000;
			rd_cnt_q              <= 5'h00;
			serial_data_out       <= 1'b0;
			serial_data_oe        <= 1'b0;
			word_valid            <= 1'b0;
			word_data             <= 18'h00000;
			word_is_data          <= 1'b0;
			parallel_data_bus_out <= 18'h00000;
			parallel_data_bus_oe  <= 1'b0;
			x_q                   <= 8'h00;
			y_q                   <= 8'h00;
			line_seen_q           <= 1'b0;
			pixel_valid           <= 1'b0;
			pixel_data            <= 18'h00000;
			pixel_x               <= 8'h00;
			pixel_y               <= 8'h00;
			frame_start           <= 1'b0;
		end else begin
			ser_state_q           <= ser_state_d;
			ser_cnt_q             <= ser_cnt_d;
			ser_sh_q              <= ser_sh_d;
			rd_sh_q               <= rd_sh_d;
			rd_cnt_q              <= rd_cnt_d;
			serial_data_out       <= sda_out_d;
			serial_data_oe        <= sda_oe_d;
			word_valid            <= word_valid_d;
			word_data             <= word_data_d;
			word_is_data          <= word_is_data_d;
			parallel_data_bus_out <= bus_out_d;
			parallel_data_bus_oe  <= bus_oe_d;
			x_q                   <= x_d;
			y_q                   <= y_d;
			line_seen_q           <= line_seen_d;
			pixel_valid           <= pix_valid_d;
			pixel_data            <= pix_data_d;
			pixel_x               <= pix_x_d;
			pixel_y               <= pix_y_d;
			frame_start           <= frame_start_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	scl_sample_a: assert property (ser_shift_ok && !scl_rise |=> ser_cnt_q == $past(ser_cnt_q))
		else $error("serial count moved without a serial clock rise");
	sda_input_only_a: assert property (serial_data_oe |-> !$past(im_s))
		else $error("serial data driven while select pin high");
	mcu_dc_class_a: assert property (word_valid && $past(mcu_word_v) |-> word_is_data == $past(dcx_s))
		else $error("MCU word class differs from data/command pin");
	rd_drive_a: assert property (mcu_active && cs_s && !rdb_s && !$past(rdb_s) |=> parallel_data_bus_oe)
		else $error("bus not driven during read strobe");
	bus_release_a: assert property (parallel_data_bus_oe |-> $past(mcu_active && !rdb_s))
		else $error("bus driven outside an MCU read");
	four_wire_dc_a: assert property (word_valid && $past(ser_word_v && four_s && !two_s)
		|-> word_is_data == $past(wrb_s))
		else $error("four-wire class not taken from write strobe pin");
	two_line_step_a: assert property (ser_shift_ok && scl_rise && two_s && ser_cnt_q != 4'h0
		|=> ser_cnt_q == 4'h0 || ser_cnt_q == $past(ser_cnt_q) + 4'h2)
		else $error("two-line mode did not take two bits");
	mcu_no_serial_a: assert property (mcu_active |=> ser_state_q == DHI_SER_IDLE)
		else $error("serial engine active in MCU mode");
	frame_start_a: assert property (rgb_active && vs_fall |=> frame_start ##1 !frame_start)
		else $error("frame sync not reported as one pulse");
	pix_expand_a: assert property (pixel_valid && $past(fmt_s)
		|-> pixel_data[12] == pixel_data[17] && pixel_data[0] == pixel_data[5])
		else $error("65k pixel not expanded");
	pix_range_a: assert property (pixel_valid |-> pixel_x < 8'hf0 && pixel_y < 8'hf0)
		else $error("pixel outside the 240x240 array");

	ser_word_c: cover property (word_valid && $past(ser_word_v));
	mcu_word_c: cover property (word_valid && $past(mcu_word_v));
	pix_last_c: cover property (pixel_valid && pixel_x == 8'hef);
	ser_read_c: cover property (ser_state_q == DHI_SER_READ ##[1:300] serial_data_oe);

endmodule : dhi_top
`default_nettype wire

// ---- sim/dhi_host_model.sv ----
// Host model that drives the serial, MCU and RGB pins of the display interface.
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model (
	input  wire logic        clk,
	input  wire logic [17:0] bus_out,
	input  wire logic        bus_oe,
	input  wire logic        sd_out,
	input  wire logic        sd_oe,
	output logic             cs_b,
	output logic             dcx,
	output logic             wr_b,
	output logic             rd_b,
	output logic      [17:0] bus_in,
	output logic             sd_in,
	output logic             pclk,
	output logic             de,
	output logic             hs_b,
	output logic             vs_b
);
	logic [17:0] hbus    = 18'h00000;
	logic        hbus_en = 1'b1;
	logic        hsd     = 1'b0;
	logic        hsd_en  = 1'b1;
	// A released line shows the inverse of the last host value, so stale data never reads as good.
	assign bus_in = bus_oe ? bus_out : (hbus_en ? hbus : ~hbus);
	assign sd_in  = sd_oe ? sd_out : (hsd_en ? hsd : ~hsd);
	initial begin
		cs_b = 1'b1;
		dcx  = 1'b1;
		wr_b = 1'b1;
		rd_b = 1'b1;
		pclk = 1'b0;
		de   = 1'b0;
		hs_b = 1'b1;
		vs_b = 1'b1;
	end
	//////////////////////////////////////////////////////////////////////////////////////////////
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	task automatic cs_set(input logic v);
		@(negedge clk);
		cs_b = v;
		wr_b = 1'b1;
		wait_n(5);
	endtask : cs_set
	// One serial clock period is eight system clocks; data changes on the serial clock fall.
	task automatic ser_bits(input int n, input logic [17:0] a, input logic [17:0] b, input logic drv,
		output logic [17:0] got);
		got    = 18'h00000;
		hsd_en = drv;
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk);
			dcx  = 1'b0;
			hsd  = a[i];
			wr_b = b[i];
			wait_n(4);
			got[i] = sd_in;
			dcx    = 1'b1;
			wait_n(3);
		end
		hsd_en = 1'b1;
	endtask : ser_bits
	task automatic mcu_write(input logic dc, input logic [17:0] d);
		@(negedge clk);
		dcx     = dc;
		hbus    = d;
		hbus_en = 1'b1;
		wait_n(3);
		wr_b = 1'b0;
		wait_n(4);
		wr_b = 1'b1;
		wait_n(4);
	endtask : mcu_write
	task automatic mcu_read(output logic [17:0] got);
		@(negedge clk);
		hbus_en = 1'b0;
		wait_n(3);
		rd_b = 1'b0;
		wait_n(6);
		got  = bus_in;
		rd_b = 1'b1;
		wait_n(6);
	endtask : mcu_read
	task automatic sync_pulse(input logic frame);
		@(negedge clk);
		de   = 1'b0;
		vs_b = ~frame;
		hs_b = frame;
		wait_n(4);
		vs_b = 1'b1;
		hs_b = 1'b1;
		wait_n(4);
	endtask : sync_pulse
	task automatic pixel(input logic [17:0] d);
		@(negedge clk);
		pclk    = 1'b0;
		de      = 1'b1;
		hbus    = d;
		hbus_en = 1'b1;
		wait_n(4);
		pclk = 1'b1;
		wait_n(3);
	endtask : pixel
endmodule : dhi_host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking testbench for the display host interface.
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
	checks++; \
	if ((got) !== (exp)) begin \
		$display("Error %s expected %h seen %h", name, exp, got); \
		fail_count++; \
	end
module tb_top
	import dhi_pkg::*;
;
	logic        clk;
	logic        rst_b;
	logic [1:0]  mode_sel;
	logic        sel_pin;
	logic        four;
	logic        two;
	logic        fmt;
	logic [17:0] read_word;
	logic        read_go;
	wire logic   cs_b, dcx, wr_b, rd_b, sd_in, pclk, de, hs_b, vs_b, bus_oe, sd_out, sd_oe;
	wire logic   word_valid, word_is_data, pixel_valid, frame_start;
	wire logic [17:0] bus_in, bus_out, word_data, pixel_data;
	wire logic [7:0]  pixel_x, pixel_y;
	int          fail_count = 0;
	int          checks     = 0;
	int          wcnt = 0, pcnt = 0, fcnt = 0, oecnt = 0;
	logic [17:0] w_d, p_d;
	logic        w_c;
	logic [7:0]  p_x, p_y;
	always #10 clk = ~clk;
	dhi_top #(.RD_BITS(8)) u_dut (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel), .interface_select_pin(sel_pin),
		.four_wire_sel(four), .two_line_sel(two), .pixel_format_65k(fmt), .chip_select_b(cs_b),
		.data_command_select(dcx), .write_strobe_b(wr_b), .read_strobe_b(rd_b), .parallel_data_bus_in(bus_in),
		.parallel_data_bus_out(bus_out), .parallel_data_bus_oe(bus_oe), .serial_data_in(sd_in),
		.serial_data_out(sd_out), .serial_data_oe(sd_oe), .dot_clock(pclk), .pixel_data_enable(de),
		.line_sync_b(hs_b), .frame_sync_b(vs_b), .read_word(read_word), .read_go(read_go),
		.word_valid(word_valid), .word_data(word_data), .word_is_data(word_is_data), .pixel_valid(pixel_valid),
		.pixel_data(pixel_data), .pixel_x(pixel_x), .pixel_y(pixel_y), .frame_start(frame_start));
	dhi_host_model u_host (.clk(clk), .bus_out(bus_out), .bus_oe(bus_oe), .sd_out(sd_out), .sd_oe(sd_oe),
		.cs_b(cs_b), .dcx(dcx), .wr_b(wr_b), .rd_b(rd_b), .bus_in(bus_in), .sd_in(sd_in), .pclk(pclk), .de(de),
		.hs_b(hs_b), .vs_b(vs_b));
	always @(posedge clk) begin
		if (word_valid === 1'b1) begin
			wcnt <= wcnt + 1;
			w_d  <= word_data;
			w_c  <= word_is_data;
		end
		if (pixel_valid === 1'b1) begin
			pcnt <= pcnt + 1;
			p_d  <= pixel_data;
			p_x  <= pixel_x;
			p_y  <= pixel_y;
		end
		if (frame_start === 1'b1) fcnt <= fcnt + 1;
		if (sd_oe === 1'b1) oecnt <= oecnt + 1;
	end
	//////////////////////////////////////////////////////////////////////////////////////////////
	task automatic cfg(input logic [1:0] m, input logic s, input logic f4, input logic f2, input logic f65);
		@(negedge clk);
		mode_sel = m;
		sel_pin  = s;
		four     = f4;
		two      = f2;
		fmt      = f65;
	endtask : cfg
	task automatic chk_word(input int base, input logic [17:0] d, input logic c);
		u_host.wait_n(3);
		`CHK("word count", base + 1, wcnt)
		`CHK("word data", d, w_d)
		`CHK("word class", c, w_c)
	endtask : chk_word
	task automatic read_pulse();
		@(negedge clk);
		read_go = 1'b1;
		@(negedge clk);
		read_go = 1'b0;
	endtask : read_pulse
	task automatic t_ser_words();
		logic [17:0] g, a, b;
		int          base, n;
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 2; c++) begin
				cfg(2'b00, 1'b1, m > 0, m == 2, 1'b0);
				n = (m == 0) ? 9 : (m == 1) ? 8 : 5;
				a = (m == 0) ? {9'h000, c[0], 8'h5a} : (m == 1) ? 18'h00096 : {13'h0000, c[0], 4'ha};
				b = (m == 1) ? {18{c[0]}} : 18'h00019;
				base = wcnt;
				u_host.cs_set(1'b0);
				u_host.ser_bits(n, a, b, 1'b1, g);
				u_host.cs_set(1'b1);
				chk_word(base, (m == 0) ? 18'h0005a : (m == 1) ? 18'h00096 : 18'h000c9, c[0]);
			end
		end
	endtask : t_ser_words
	task automatic t_ser_drop();
		logic [17:0] g;
		int          base;
		cfg(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
		base = wcnt;
		u_host.cs_set(1'b0);
		u_host.ser_bits(5, 18'h0001f, 18'h3ffff, 1'b1, g);
		u_host.cs_set(1'b1);
		u_host.cs_set(1'b0);
		u_host.ser_bits(9, 18'h00181, 18'h3ffff, 1'b1, g);
		u_host.cs_set(1'b1);
		chk_word(base, 18'h00081, 1'b1);
	endtask : t_ser_drop
	task automatic t_ser_read();
		logic [17:0] g;
		int          base;
		cfg(2'b00, 1'b0, 1'b0, 1'b0, 1'b0);
		read_word = 18'h2b5a7;
		u_host.cs_set(1'b0);
		read_pulse();
		u_host.ser_bits(8, 18'h00000, 18'h3ffff, 1'b0, g);
		`CHK("serial read", 8'ha7, g[7:0])
		`CHK("serial oe held", 1'b1, sd_oe)
		u_host.ser_bits(1, 18'h00000, 18'h3ffff, 1'b0, g);
		u_host.cs_set(1'b1);
		`CHK("serial oe released", 1'b0, sd_oe)
		cfg(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
		base = oecnt;
		u_host.cs_set(1'b0);
		read_pulse();
		u_host.ser_bits(8, 18'h00055, 18'h3ffff, 1'b1, g);
		u_host.cs_set(1'b1);
		`CHK("input only oe", base, oecnt)
	endtask : t_ser_read
	task automatic t_mcu();
		logic [17:0] g;
		int          base;
		cfg(2'b01, 1'b1, 1'b0, 1'b0, 1'b0);
		u_host.cs_set(1'b0);
		base = wcnt;
		u_host.mcu_write(1'b1, 18'h3ffff);
		chk_word(base, 18'h3ffff, 1'b1);
		base = wcnt;
		u_host.mcu_write(1'b0, 18'h20001);
		chk_word(base, 18'h20001, 1'b0);
		read_word = 18'h1ead9;
		u_host.mcu_read(g);
		`CHK("mcu read", 18'h1ead9, g)
		`CHK("bus oe released", 1'b0, bus_oe)
		u_host.cs_set(1'b1);
		base = wcnt;
		u_host.mcu_write(1'b1, 18'h15555);
		u_host.wait_n(3);
		`CHK("deselected write", base, wcnt)
	endtask : t_mcu
	task automatic t_rgb();
		int base, f;
		cfg(2'b10, 1'b1, 1'b0, 1'b0, 1'b0);
		base = pcnt;
		f    = fcnt;
		u_host.sync_pulse(1'b1);
		u_host.sync_pulse(1'b0);
		for (int i = 0; i <= DHI_COLS; i++) u_host.pixel(i[17:0]);
		u_host.wait_n(5);
		`CHK("frame starts", f + 1, fcnt)
		`CHK("pixels kept", base + DHI_COLS, pcnt)
		`CHK("last x", 8'hef, p_x)
		`CHK("last pixel", 18'h000ef, p_d)
		`CHK("first line y", 8'h00, p_y)
		u_host.sync_pulse(1'b0);
		cfg(2'b10, 1'b1, 1'b0, 1'b0, 1'b1);
		u_host.pixel(18'h0ae6b);
		u_host.wait_n(5);
		`CHK("second line y", 8'h01, p_y)
		`CHK("second line x", 8'h00, p_x)
		`CHK("565 pixel", 16'hae6b, {p_d[17:13], p_d[11:6], p_d[5:1]})
	endtask : t_rgb
	//////////////////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		#400us;
		fail_count++;
		complete_run();
	end
	initial begin
		clk       = 1'b0;
		rst_b     = 1'b0;
		mode_sel  = 2'b00;
		sel_pin   = 1'b1;
		four      = 1'b0;
		two       = 1'b0;
		fmt       = 1'b0;
		read_word = 18'h00000;
		read_go   = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		u_host.wait_n(6);
		t_ser_words();
		t_ser_drop();
		t_ser_read();
		t_mcu();
		t_rgb();
		complete_run();
	end
endmodule : tb_top
`undef CHK
`default_nettype wire
